// ===== design/assp_pkg.sv
// package: shared constants and types of the async/sync serial port
package assp_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int DATA_W = 9;
  localparam int DEPTH = 8;
  localparam int LVL_W = 4;
  localparam int BAUD_W = 13;
  localparam int FRAC_W = 10;
  localparam int FRAME_W = 12;
  localparam int RXSH_W = 10;

  // ****************************************
  // bit timing in baud ticks, frame lengths in bits
  // ****************************************
  localparam logic [3:0] ASY_LAST = 4'hF;
  localparam logic [3:0] ASY_MID = 4'h7;
  localparam logic [2:0] SYN_LAST = 3'h7;
  localparam logic [2:0] SYN_MID = 3'h3;
  localparam logic [3:0] IRDA_PULSE = 4'h3;
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [3:0] RXSH_LEN = 4'hA;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SHIFT = 2'b11
  } assp_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b11,
    RX_STOP = 2'b10
  } assp_rx_e;

  // parity over 8 or 9 data bits, odd flips the sense
  function automatic logic parOf(logic [8:0] d, logic nine, logic odd);
    parOf = (^d[7:0]) ^ (nine & d[8]) ^ odd;
  endfunction

endpackage

// ===== design/assp_fifo_if.sv
// interface: push/pop side bundle between the port and one queue
`timescale 1ns/1ps
interface assp_fifo_if;
  logic push;
  logic [assp_pkg::DATA_W-1:0] wData;
  logic full;
  logic pop;
  logic [assp_pkg::DATA_W-1:0] rData;
  logic rValid;
  logic empty;
  logic [assp_pkg::LVL_W-1:0] level;
  logic ovf;
  logic udf;
  modport queue (input push, wData, pop,
    output full, empty, level, rData, rValid, ovf, udf);
  modport owner (output push, wData, pop,
    input full, empty, level, rData, rValid, ovf, udf);
endinterface

// ===== design/assp_queue.sv
// module: 9-bit queue memory with fill level and fault flags
`timescale 1ns/1ps
module assp_queue #(
  parameter int W = assp_pkg::DATA_W,
  parameter int D = assp_pkg::DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  assp_fifo_if.queue q
);
  // pointers wrap by width, so D must be a power of two
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [assp_pkg::LVL_W-1:0] count_q;
  logic [W-1:0] rData_q;
  logic rValid_q;
  logic ovf_q;
  logic udf_q;
  wire doPush = q.push && !q.full;
  wire doPop = q.pop && !q.empty;

  assign q.full = count_q == assp_pkg::LVL_W'(D);
  assign q.empty = count_q == '0;
  assign q.level = count_q;
  assign q.rData = rData_q;
  assign q.rValid = rValid_q;
  assign q.ovf = ovf_q;
  assign q.udf = udf_q;

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q] <= q.wData;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      rData_q <= '0;
      rValid_q <= 1'b0;
      ovf_q <= 1'b0;
      udf_q <= 1'b0;
    end else begin
      if (doPush) wrPtr_q <= wrPtr_q + 1'b1;
      if (doPop) rdPtr_q <= rdPtr_q + 1'b1;
      if (doPop) rData_q <= mem[rdPtr_q];
      count_q <= count_q + assp_pkg::LVL_W'(doPush)
        - assp_pkg::LVL_W'(doPop);
      rValid_q <= doPop;
      ovf_q <= q.push && q.full;
      udf_q <= q.pop && q.empty;
    end
  end
endmodule

// ===== design/assp_baud.sv
// module: fractional prescaler followed by the 13-bit reload counter
`timescale 1ns/1ps
module assp_baud (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic [assp_pkg::FRAC_W-1:0] fracStep,
  input wire logic [assp_pkg::BAUD_W-1:0] reload,
  output logic tick
);
  logic [assp_pkg::FRAC_W-1:0] acc_q;
  logic [assp_pkg::BAUD_W-1:0] cnt_q;
  logic tick_q;
  logic [assp_pkg::FRAC_W:0] sum;
  logic fdTick;

  // step zero bypasses the prescaler, else carry-out is the tick
  assign sum = {1'b0, acc_q} + {1'b0, fracStep};
  assign fdTick = enable && (fracStep == '0 || sum[assp_pkg::FRAC_W]);
  assign tick = tick_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_q <= '0;
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (!enable) begin
      acc_q <= '0;
      cnt_q <= reload;
      tick_q <= 1'b0;
    end else begin
      acc_q <= sum[assp_pkg::FRAC_W-1:0];
      tick_q <= fdTick && cnt_q == '0;
      if (fdTick) begin
        cnt_q <= (cnt_q == '0) ? reload : cnt_q - 1'b1;
      end
    end
  end
endmodule

// ===== design/assp_top.sv
// module: async/sync serial port with framing, queues and pin control
`timescale 1ns/1ps
// Functional notes
// - async full duplex, sync half duplex, own clock
// - sync mode drives receive line only when sending; transmit always out
// - 8 or 9 data bits, LSB first
// - parity generated on send, checked on receive
// - one or two stop bits selectable
// - parity, frame, overrun errors raise error request
// - transmitter and receiver double buffered
// - multiprocessor mode flags address bytes
// - loop-back feeds transmit line into receiver
// - sync transfers are 8-bit half duplex
// - 13-bit baud counter behind fractional prescaler
// - async rate is module clock over sixteen
// - sync rate is module clock over eight
// - IrDA coding usable up to 115.2 kBaud
// - separate tx-empty, last-bit, rx-full, error requests
// - two independent 8-deep 9-bit queues
// - programmable trigger level per queue
// - queue levels shown; overrun and underflow flagged
module assp_top #(
  parameter int QUEUE_DEPTH = assp_pkg::DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic runEn,
  input wire logic syncMode,
  input wire logic nineBit,
  input wire logic parEn,
  input wire logic parOdd,
  input wire logic twoStop,
  input wire logic mpEn,
  input wire logic loopBack,
  input wire logic irdaEn,
  input wire logic rxEnable,
  input wire logic [assp_pkg::FRAC_W-1:0] fracStep,
  input wire logic [assp_pkg::BAUD_W-1:0] baudReload,
  input wire logic [assp_pkg::LVL_W-1:0] txTrig,
  input wire logic [assp_pkg::LVL_W-1:0] rxTrig,
  input wire logic txValid,
  input wire logic [assp_pkg::DATA_W-1:0] txData,
  output logic txReady,
  output logic rxValid,
  output logic [assp_pkg::DATA_W-1:0] rxData,
  input wire logic rxReady,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe_n,
  output logic txdOut,
  output logic txBufReq,
  output logic txLastReq,
  output logic rxBufReq,
  output logic errReq,
  output logic errParity,
  output logic errFrame,
  output logic errOverrun,
  output logic rxAddrDet,
  output logic txOverflow,
  output logic queueUnderflow,
  output logic [assp_pkg::LVL_W-1:0] txLevel,
  output logic [assp_pkg::LVL_W-1:0] rxLevel,
  output logic busy
);
  // ****************************************
  // baud generator and queues
  // ****************************************
  logic brTick;
  assp_fifo_if txq ();
  assp_fifo_if rxq ();

  assp_baud u_baud (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(runEn),
    .fracStep(fracStep),
    .reload(baudReload),
    .tick(brTick)
  );

  assp_queue #(.D(QUEUE_DEPTH)) transmit_queue (
    .clk_sys(clk_sys),
    .rst(rst),
    .q(txq.queue)
  );

  assp_queue #(.D(QUEUE_DEPTH)) receive_queue (
    .clk_sys(clk_sys),
    .rst(rst),
    .q(rxq.queue)
  );

  assign txq.push = txValid;
  assign txq.wData = txData;
  assign txReady = !txq.full;
  assign txLevel = txq.level;
  assign rxLevel = rxq.level;
  assign txOverflow = txq.ovf;
  assign queueUnderflow = rxq.udf || txq.udf;
  assign txBufReq = txq.level <= txTrig;
  assign rxBufReq = rxq.level != '0 && rxq.level >= rxTrig;

  // frame bits after the start bit; unused upper bits stay as stop
  function automatic logic [assp_pkg::FRAME_W-1:0] txFrame(
    logic [8:0] d, logic nine, logic pe, logic odd);
    logic [assp_pkg::FRAME_W-1:0] f;
    f = '1;
    f[7:0] = d[7:0];
    if (nine) f[8] = d[8];
    if (pe) f[nine ? 9 : 8] = assp_pkg::parOf(d, nine, odd);
    txFrame = f;
  endfunction

  // ****************************************
  // transmitter and sync sequencer
  // ****************************************
  assp_pkg::assp_tx_e txSt_q;
  logic [assp_pkg::FRAME_W:0] txSh_q;
  logic [3:0] txCnt_q;
  logic [3:0] txOv_q;
  logic txDir_q;
  logic txdOut_q;
  logic rxdOut_q;
  logic rxdOe_n_q;
  logic txLast_q;

  wire [3:0] dataBits = nineBit ? assp_pkg::BITS9 : assp_pkg::BITS8;
  wire [3:0] frameLen = 4'(1 + dataBits + 4'(parEn) + (twoStop ? 2 : 1));
  wire asyLast = brTick && txOv_q == assp_pkg::ASY_LAST;
  wire synLast = brTick && txOv_q[2:0] == assp_pkg::SYN_LAST;
  wire synMid = brTick && txOv_q[2:0] == assp_pkg::SYN_MID;
  wire txBitEnd = syncMode ? synLast : asyLast;
  wire txShift = txSt_q == assp_pkg::TX_SHIFT;
  wire txEnd = txShift && txBitEnd && txCnt_q == 4'h1;
  wire txIdle = txSt_q == assp_pkg::TX_IDLE;
  wire txGo = txIdle && runEn && !txq.empty;
  // sync receive only starts when nothing waits to go out
  wire synRxGo = txIdle && runEn && syncMode && rxEnable && txq.empty;
  wire synRxDone = txEnd && syncMode && !txDir_q;
  wire txLine = txShift ? txSh_q[0] : 1'b1;
  wire irdaHigh = txOv_q >= assp_pkg::IRDA_PULSE;
  // irda: a zero is a short low pulse, a one keeps the line high
  wire asyTxd = txLine || (irdaEn && irdaHigh);
  wire synClk = txShift ? txOv_q[2] : 1'b1;
  wire txd_d = syncMode ? synClk : asyTxd;

  assign txq.pop = txGo;
  assign txdOut = txdOut_q;
  assign rxdOut = rxdOut_q;
  assign rxdOe_n = rxdOe_n_q;
  assign txLastReq = txLast_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txSt_q <= assp_pkg::TX_IDLE;
      txSh_q <= '1;
      txCnt_q <= '0;
      txOv_q <= '0;
      txDir_q <= 1'b0;
    end else begin
      if (brTick) txOv_q <= txOv_q + 1'b1;
      case (txSt_q)
        assp_pkg::TX_IDLE: begin
          txOv_q <= '0;
          if (txGo) begin
            txSt_q <= assp_pkg::TX_LOAD;
          end else if (synRxGo) begin
            txSt_q <= assp_pkg::TX_SHIFT;
            txSh_q <= '1;
            txCnt_q <= assp_pkg::BITS8;
            txDir_q <= 1'b0;
          end
        end
        assp_pkg::TX_LOAD: begin
          txOv_q <= '0;
          if (txq.rValid) begin
            txSt_q <= assp_pkg::TX_SHIFT;
            txDir_q <= 1'b1;
            if (syncMode) begin
              txSh_q <= {5'h1F, txq.rData[7:0]};
              txCnt_q <= assp_pkg::BITS8;
            end else begin
              txSh_q <= {txFrame(txq.rData, nineBit, parEn, parOdd),
                1'b0};
              txCnt_q <= frameLen;
            end
          end
        end
        assp_pkg::TX_SHIFT: begin
          if (syncMode && !txDir_q && synMid) begin
            txSh_q <= {txSh_q[12:8], rxdIn, txSh_q[7:1]};
          end else if (txBitEnd && txDir_q) begin
            txSh_q <= {1'b1, txSh_q[12:1]};
          end
          if (txBitEnd) begin
            txCnt_q <= txCnt_q - 1'b1;
            if (txCnt_q == 4'h1) txSt_q <= assp_pkg::TX_IDLE;
          end
        end
        default: txSt_q <= assp_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txdOut_q <= 1'b1;
      rxdOut_q <= 1'b1;
      rxdOe_n_q <= 1'b1;
      txLast_q <= 1'b0;
    end else begin
      txdOut_q <= txd_d;
      rxdOut_q <= txLine;
      rxdOe_n_q <= !(syncMode && txShift && txDir_q);
      txLast_q <= txEnd && txDir_q;
    end
  end

  // ****************************************
  // asynchronous receiver
  // ****************************************
  assp_pkg::assp_rx_e rxSt_q;
  logic [assp_pkg::RXSH_W-1:0] rxSh_q;
  logic [3:0] rxCnt_q;
  logic [3:0] rxOv_q;
  logic rxPrev_q;
  logic lowSeen_q;
  logic stopLeft_q;
  logic frameBad_q;
  logic errParity_q;
  logic errFrame_q;
  logic rxAddr_q;

  wire rxLine = loopBack ? txdOut_q : rxdIn;
  // irda pulses may miss the centre, so any low in the bit means zero
  wire rxBit = irdaEn ? !(lowSeen_q || !rxLine) : rxLine;
  wire rxMid = brTick && rxOv_q == assp_pkg::ASY_MID;
  wire rxFall = brTick && rxPrev_q && !rxLine;
  wire rxIdle = rxSt_q == assp_pkg::RX_IDLE;
  wire rxArm = runEn && rxEnable && !syncMode;
  wire [3:0] rxBits = dataBits + 4'(parEn);
  wire [assp_pkg::RXSH_W-1:0] rxAl = rxSh_q >> (assp_pkg::RXSH_LEN - rxBits);
  wire [8:0] rxWord = nineBit ? rxAl[8:0] : {1'b0, rxAl[7:0]};
  wire rxParBit = nineBit ? rxAl[9] : rxAl[8];
  wire rxDone = rxSt_q == assp_pkg::RX_STOP && rxMid && !stopLeft_q;
  wire parBad = parEn &&
    assp_pkg::parOf(rxWord, nineBit, parOdd) != rxParBit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxSt_q <= assp_pkg::RX_IDLE;
      rxSh_q <= '0;
      rxCnt_q <= '0;
      rxOv_q <= '0;
      rxPrev_q <= 1'b1;
      lowSeen_q <= 1'b0;
      stopLeft_q <= 1'b0;
      frameBad_q <= 1'b0;
    end else begin
      if (brTick) rxPrev_q <= rxLine;
      if (brTick) rxOv_q <= rxOv_q + 1'b1;
      if (rxMid || rxIdle) lowSeen_q <= 1'b0;
      else if (!rxLine) lowSeen_q <= 1'b1;
      case (rxSt_q)
        assp_pkg::RX_IDLE: begin
          if (rxFall && rxArm) begin
            rxSt_q <= assp_pkg::RX_START;
            rxOv_q <= '0;
            lowSeen_q <= 1'b1;
          end
        end
        assp_pkg::RX_START: begin
          if (rxMid) begin
            rxSt_q <= rxBit ? assp_pkg::RX_IDLE : assp_pkg::RX_BITS;
            rxCnt_q <= rxBits;
            frameBad_q <= 1'b0;
          end
        end
        assp_pkg::RX_BITS: begin
          if (rxMid) begin
            rxSh_q <= {rxBit, rxSh_q[9:1]};
            rxCnt_q <= rxCnt_q - 1'b1;
            if (rxCnt_q == 4'h1) rxSt_q <= assp_pkg::RX_STOP;
            stopLeft_q <= twoStop;
          end
        end
        assp_pkg::RX_STOP: begin
          if (rxMid) begin
            if (!rxBit) frameBad_q <= 1'b1;
            stopLeft_q <= 1'b0;
            if (!stopLeft_q) rxSt_q <= assp_pkg::RX_IDLE;
          end
        end
        default: rxSt_q <= assp_pkg::RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // receive push, errors and requests
  // ****************************************
  assign rxq.push = rxDone || synRxDone;
  assign rxq.wData = synRxDone ? {1'b0, txSh_q[7:0]} : rxWord;
  assign errParity = errParity_q;
  assign errFrame = errFrame_q;
  assign errOverrun = rxq.ovf;
  assign errReq = errParity_q || errFrame_q || rxq.ovf;
  assign rxAddrDet = rxAddr_q;
  assign busy = !txIdle || !rxIdle;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      errParity_q <= 1'b0;
      errFrame_q <= 1'b0;
      rxAddr_q <= 1'b0;
    end else begin
      errParity_q <= rxDone && parBad;
      errFrame_q <= rxDone && (frameBad_q || !rxBit);
      rxAddr_q <= rxDone && mpEn && nineBit && rxWord[8];
    end
  end

  // ****************************************
  // two-entry output buffer toward the reader
  // ****************************************
  logic [assp_pkg::DATA_W-1:0] ob0_q;
  logic [assp_pkg::DATA_W-1:0] ob1_q;
  logic [1:0] obCnt_q;

  // a word in flight from the queue counts against free room
  wire obTake = rxValid && rxReady;
  wire obIn = rxq.rValid;
  assign rxq.pop = !rxq.empty &&
    (obCnt_q == 2'h0 || (obCnt_q == 2'h1 && !obIn));
  assign rxValid = obCnt_q != 2'h0;
  assign rxData = ob0_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ob0_q <= '0;
      ob1_q <= '0;
      obCnt_q <= '0;
    end else begin
      if (obIn && !obTake) begin
        if (obCnt_q == 2'h0) ob0_q <= rxq.rData;
        else ob1_q <= rxq.rData;
        obCnt_q <= obCnt_q + 1'b1;
      end else if (obTake && !obIn) begin
        ob0_q <= ob1_q;
        obCnt_q <= obCnt_q - 1'b1;
      end else if (obTake && obIn) begin
        if (obCnt_q == 2'h1) begin
          ob0_q <= rxq.rData;
        end else begin
          ob0_q <= ob1_q;
          ob1_q <= rxq.rData;
        end
      end
    end
  end
endmodule

// ===== verification/assp_props.sv
// checker: port-level properties of the serial port top
`timescale 1ns/1ps
module assp_props #(
  parameter int QUEUE_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic syncMode,
  input wire logic irdaEn,
  input wire logic [assp_pkg::LVL_W-1:0] txTrig,
  input wire logic [assp_pkg::LVL_W-1:0] rxTrig,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic [assp_pkg::DATA_W-1:0] rxData,
  input wire logic rxReady,
  input wire logic rxdOe_n,
  input wire logic txdOut,
  input wire logic txBufReq,
  input wire logic txLastReq,
  input wire logic rxBufReq,
  input wire logic errReq,
  input wire logic errParity,
  input wire logic errFrame,
  input wire logic errOverrun,
  input wire logic txOverflow,
  input wire logic [assp_pkg::LVL_W-1:0] txLevel,
  input wire logic [assp_pkg::LVL_W-1:0] rxLevel,
  input wire logic busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ****
  // requests and queues
  // ****
  property p_txReq;
    txBufReq == (txLevel <= txTrig);
  endproperty
  a_txReq: assert property (p_txReq) else $error("txBufReq wrong");
  property p_rxReq;
    rxBufReq == (rxLevel != 4'h0 && rxLevel >= rxTrig);
  endproperty
  a_rxReq: assert property (p_rxReq) else $error("rxBufReq wrong");
  property p_err;
    errReq == (errParity | errFrame | errOverrun);
  endproperty
  a_err: assert property (p_err) else $error("errReq wrong");
  property p_ready;
    txReady == (txLevel != QUEUE_DEPTH);
  endproperty
  a_ready: assert property (p_ready) else $error("txReady wrong");
  property p_ovf;
    txValid && !txReady |=> txOverflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow pulse");
  property p_hold;
    rxValid && !rxReady |=> rxValid && $stable(rxData);
  endproperty
  a_hold: assert property (p_hold) else $error("rx word lost");
  // ****
  // pins
  // ****
  // a bit lasts at least sixteen clocks, so eight low cycles are safe
  property p_minLow;
    $fell(txdOut) && !syncMode && !irdaEn |-> (!txdOut)[*8];
  endproperty
  a_minLow: assert property (p_minLow) else $error("bit too short");
  property p_oe;
    !rxdOe_n |-> syncMode && $past(busy);
  endproperty
  a_oe: assert property (p_oe) else $error("rxd driven");
  property p_last;
    txLastReq |-> txdOut ##1 !txLastReq;
  endproperty
  a_last: assert property (p_last) else $error("last-bit pulse");
  c_ovf: cover property (txOverflow);
  c_par: cover property (errParity);
  c_sync: cover property (!rxdOe_n);
endmodule
bind assp_top assp_props #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_props (
  .clk_sys, .rst, .syncMode, .irdaEn, .txTrig, .rxTrig, .txValid,
  .txReady, .rxValid, .rxData, .rxReady, .rxdOe_n, .txdOut, .txBufReq,
  .txLastReq, .rxBufReq, .errReq, .errParity, .errFrame, .errOverrun,
  .txOverflow, .txLevel, .rxLevel, .busy
);

// ===== verification/assp_peer.sv
// model: remote async serial device at the far end of the link
`timescale 1ns/1ps
module assp_peer (
  input wire logic clk_sys,
  input wire logic line,
  input wire logic nineBit,
  input wire logic parEn,
  input wire logic twoStop,
  input wire logic syncMode,
  input wire logic [7:0] bitCyc,
  output logic drive
);
  logic [10:0] gotQ[$];
  logic [8:0] w;
  logic p;
  logic s;
  // ****
  // receiver: centre sampling
  // ****
  initial begin
    drive = 1'b1;
    forever begin
      @(negedge line);
      repeat (bitCyc / 2) @(posedge clk_sys);
      if (!line && !syncMode) begin
        w = 9'h000;
        p = 1'b0;
        for (int i = 0; i < (nineBit ? 9 : 8); i++) begin
          repeat (bitCyc) @(posedge clk_sys);
          w[i] = line;
        end
        if (parEn) begin
          repeat (bitCyc) @(posedge clk_sys);
          p = line;
        end
        repeat (bitCyc) @(posedge clk_sys);
        s = line;
        if (twoStop) begin
          repeat (bitCyc) @(posedge clk_sys);
          s = s & line;
        end
        gotQ.push_back({s, p, w});
      end
    end
  end
  // ****
  // sender: one stop, then idle high for resync
  // ****
  task automatic send(logic [8:0] d, logic pb, logic badStop);
    drive <= 1'b0;
    repeat (bitCyc) @(posedge clk_sys);
    for (int i = 0; i < (nineBit ? 9 : 8); i++) begin
      drive <= d[i];
      repeat (bitCyc) @(posedge clk_sys);
    end
    if (parEn) begin
      drive <= pb;
      repeat (bitCyc) @(posedge clk_sys);
    end
    drive <= !badStop;
    repeat (bitCyc) @(posedge clk_sys);
    drive <= 1'b1;
    repeat (2 * bitCyc) @(posedge clk_sys);
  endtask
endmodule

// ===== verification/tb.sv
// testbench: self-checking run of the serial port against a remote model
`timescale 1ns/1ps
module tb;
  localparam int QD = assp_pkg::DEPTH;
  logic clk_sys, rst, runEn, syncMode, nineBit, parEn, parOdd, twoStop;
  logic mpEn, loopBack, rxEnable, txValid, rxReady, syncDrv, peerDrv;
  logic txReady, rxValid, rxdOut, rxdOe_n, txdOut, busy, irdaEn;
  logic errParity, errFrame, errOverrun, rxAddrDet, txOverflow;
  logic [assp_pkg::BAUD_W-1:0] baudReload;
  logic [assp_pkg::FRAC_W-1:0] fracStep;
  logic [8:0] txData;
  logic [8:0] rxData;
  logic [3:0] txLevel;
  logic [3:0] rxLevel;
  logic [7:0] bitCyc;
  logic [4:0] fmts [4] = '{5'b00000, 5'b01000, 5'b01110, 5'b10000};
  wire logic rxdPin;
  int badCount = 0, checks = 0;
  int nPar = 0, nFrm = 0, nOvr = 0, nAdr = 0, nOvf = 0;

  assp_top #(.QUEUE_DEPTH(QD)) i_dut (
    .clk_sys, .rst, .runEn, .syncMode, .nineBit, .parEn, .parOdd,
    .twoStop, .mpEn, .loopBack, .irdaEn, .rxEnable,
    .fracStep, .baudReload, .txTrig(4'h2), .rxTrig(4'h4),
    .txValid, .txData, .txReady, .rxValid, .rxData, .rxReady,
    .rxdIn(rxdPin), .rxdOut, .rxdOe_n, .txdOut, .txBufReq(),
    .txLastReq(), .rxBufReq(), .errReq(), .errParity, .errFrame,
    .errOverrun, .rxAddrDet, .txOverflow, .queueUnderflow(), .txLevel,
    .rxLevel, .busy
  );
  assp_peer i_peer (
    .clk_sys, .line(txdOut), .nineBit, .parEn, .twoStop, .syncMode,
    .bitCyc, .drive(peerDrv)
  );
  // ****
  // pin resolution and event counters
  // ****
  assign rxdPin = !rxdOe_n ? rxdOut : (syncMode ? syncDrv : peerDrv);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (!rst) begin
      nPar <= nPar + errParity;
      nFrm <= nFrm + errFrame;
      nOvr <= nOvr + errOverrun;
      nAdr <= nAdr + rxAddrDet;
      nOvf <= nOvf + txOverflow;
    end
  end
  // ****
  // access tasks
  // ****
  task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic par(logic [8:0] d);
    par = parOdd ^ (^d[7:0]) ^ (nineBit & d[8]);
  endfunction
  task automatic wr(logic [8:0] d);
    txValid <= 1'b1;
    txData <= d;
    for (int k = 0; k < 9999; k++) begin
      @(negedge clk_sys);
      if (txReady === 1'b1) break;
    end
    @(posedge clk_sys);
    txValid <= 1'b0;
  endtask
  task automatic rd(output logic [8:0] d, input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (k < lim && rxValid !== 1'b1);
    d = rxData;
    if (rxValid === 1'b1) begin
      @(posedge clk_sys);
      rxReady <= 1'b1;
      @(posedge clk_sys);
      rxReady <= 1'b0;
    end
  endtask
  // two words back to back, so a missing second stop shows up
  task automatic txChk(logic [8:0] d);
    logic [10:0] g;
    logic [8:0] e;
    i_peer.gotQ.delete();
    wr(d);
    @(posedge clk_sys);
    wr(~d);
    for (int k = 0; k < 9999 && i_peer.gotQ.size() < 2; k++)
      @(posedge clk_sys);
    for (int k = 0; k < 2; k++) begin
      e = (k ? ~d : d) & (nineBit ? 9'h1FF : 9'h0FF);
      g = i_peer.gotQ.pop_front();
      chk("txWord", g[8:0], e);
      chk("txPar", 9'(g[9]), 9'(parEn & par(e)));
      chk("txStop", 9'(g[10]), 9'h001);
    end
  endtask
  task automatic rxChk(logic [8:0] d, logic bp, logic bs);
    logic [8:0] g;
    logic [8:0] e;
    e = d & (nineBit ? 9'h1FF : 9'h0FF);
    i_peer.send(e, par(e) ^ bp, bs);
    rd(g, 400);
    chk("rxWord", g, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    badCount++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish();
  end
  // ****
  // test sequence
  // ****
  initial begin
    logic [8:0] g;
    int n;
    realtime t0;
    rst = 1'b1;
    runEn = 1'b1;
    syncMode = 1'b0;
    {nineBit, parEn, parOdd, twoStop, mpEn} = 5'b00000;
    loopBack = 1'b0;
    irdaEn = 1'b0;
    fracStep = 10'h000;
    rxEnable = 1'b1;
    txValid = 1'b0;
    rxReady = 1'b0;
    syncDrv = 1'b1;
    baudReload = 13'h0000;
    txData = 9'h000;
    bitCyc = 8'h10;
    repeat (16) @(posedge clk_sys);
    chk("idleTx", 9'(txdOut), 9'h001);
    chk("rxdOe", 9'(rxdOe_n), 9'h001);
    chk("txLevel", 9'(txLevel), 9'h000);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {nineBit, parEn, parOdd, twoStop, mpEn} <= fmts[i];
      baudReload <= 13'(i);
      // last format halves the prescaler rate, so bits double
      fracStep <= (i == 3) ? 10'h200 : 10'h000;
      bitCyc <= (i == 3) ? 8'h80 : 8'(16 * (i + 1));
      @(posedge clk_sys);
      txChk(9'h1A5 ^ 9'(i));
      rxChk(9'h15A ^ 9'(i), 1'b0, 1'b0);
    end
    $display("test formats done");
    {nineBit, parEn, parOdd, twoStop, mpEn} <= 5'b01000;
    baudReload <= 13'h0000;
    bitCyc <= 8'h10;
    fracStep <= 10'h000;
    @(posedge clk_sys);
    n = nPar;
    rxChk(9'h033, 1'b1, 1'b0);
    chk("parErr", 9'(nPar - n), 9'h001);
    n = nFrm;
    rxChk(9'h0CC, 1'b0, 1'b1);
    chk("frmErr", 9'(nFrm - n), 9'h001);
    {nineBit, parEn, parOdd, twoStop, mpEn} <= 5'b10001;
    @(posedge clk_sys);
    n = nAdr;
    rxChk(9'h1C3, 1'b0, 1'b0);
    rxChk(9'h0C3, 1'b0, 1'b0);
    chk("addrDet", 9'(nAdr - n), 9'h001);
    {nineBit, parEn, parOdd, twoStop, mpEn} <= 5'b00000;
    loopBack <= 1'b1;
    @(posedge clk_sys);
    wr(9'h05A);
    rd(g, 400);
    chk("loop", g, 9'h05A);
    irdaEn <= 1'b1;
    wr(9'h0A5);
    rd(g, 400);
    chk("irda", g, 9'h0A5);
    irdaEn <= 1'b0;
    loopBack <= 1'b0;
    runEn <= 1'b0;
    $display("test errors and loop done");
    @(posedge clk_sys);
    i_peer.gotQ.delete();
    n = 0;
    txValid <= 1'b1;
    txData <= 9'h000;
    while (n < 20) begin
      @(negedge clk_sys);
      if (txReady !== 1'b1) break;
      n++;
      @(posedge clk_sys);
      txData <= 9'(n);
    end
    chk("fillLvl", 9'(txLevel), 9'(QD));
    @(posedge clk_sys);
    txValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("txOvf", 9'(nOvf), 9'h001);
    runEn <= 1'b1;
    for (int k = 0; k < 9999 && i_peer.gotQ.size() < n; k++)
      @(posedge clk_sys);
    chk("drained", 9'(i_peer.gotQ.size()), 9'(n));
    for (int k = 0; k < n; k++)
      chk("order", 9'(i_peer.gotQ[k][7:0]), 9'(k));
    $display("test tx queue done");
    n = nOvr;
    for (int k = 0; k < 13; k++)
      i_peer.send(9'(k), 1'b0, 1'b0);
    chk("rxFull", 9'(rxLevel), 9'(QD));
    chk("rxOvr", 9'(nOvr > n), 9'h001);
    rd(g, 20);
    chk("oldest", g, 9'h000);
    for (int k = 0; k < 13; k++)
      rd(g, 20);
    chk("rxEmpty", 9'(rxLevel), 9'h000);
    $display("test rx queue done");
    for (int k = 0; k < 999 && busy !== 1'b0; k++)
      @(posedge clk_sys);
    syncMode <= 1'b1;
    rxEnable <= 1'b0;
    @(posedge clk_sys);
    wr(9'h1A5);
    for (int b = 0; b < 8; b++) begin
      @(posedge txdOut);
      if (b == 1)
        chk("synPer", 9'(int'(($realtime - t0) / 5)), 9'h008);
      t0 = $realtime;
      g[b] = rxdOut;
      chk("oeLow", 9'(rxdOe_n), 9'h000);
    end
    chk("syncTx", 9'(g[7:0]), 9'h0A5);
    for (int k = 0; k < 999 && busy !== 1'b0; k++)
      @(posedge clk_sys);
    rxEnable <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      @(negedge txdOut);
      @(posedge clk_sys);
      syncDrv <= 1'(8'h3C >> b);
    end
    rd(g, 400);
    chk("syncRx", g, 9'h03C);
    $display("test sync done");
    tally_and_finish();
  end
endmodule
